// ---- common/atd_pkg.sv ----
// Purpose: Shared constants and types for the asynchronous descriptor executor.
// Assumes: 32-bit AXI4-Lite register access, one descriptor held in four words.
// Notes: Field positions are bit positions inside each 32-bit descriptor word.
package atd_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_WORD0 = 8'h00;
  localparam logic [7:0] OFS_WORD1 = 8'h04;
  localparam logic [7:0] OFS_WORD2 = 8'h08;
  localparam logic [7:0] OFS_WORD3 = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CPU_ADDR = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int W0_VALID = 0;
  localparam int W0_LEN_LO = 3;
  localparam int W0_MAXPKT_LO = 18;
  localparam int W0_MULT_LO = 29;
  localparam int W0_EP_LOW = 31;
  localparam int W1_EP_HI_LO = 0;
  localparam int W1_FUNC_LO = 3;
  localparam int W1_TOKEN_LO = 10;
  localparam int W1_KIND_LO = 12;
  localparam int W1_SPLIT = 14;
  localparam int W2_PTR_LO = 8;
  localparam int W2_RELOAD_LO = 25;
  localparam int W3_DONE_LO = 0;
  localparam int W3_NAK_LO = 19;
  localparam int W3_RETRY_LO = 23;
  localparam int W3_XERR = 28;
  localparam int W3_ACTIVE = 31;

  // ---------------------------------------------------------------
  // Encodings, reset values and address mapping
  // ---------------------------------------------------------------
  localparam logic [1:0] KIND_CONTROL = 2'h0;
  localparam logic [1:0] KIND_BULK = 2'h2;
  localparam logic [1:0] TOKEN_OUT = 2'h0;
  localparam logic [1:0] TOKEN_IN = 2'h1;
  localparam logic [1:0] TOKEN_SETUP = 2'h2;
  localparam logic [1:0] TOKEN_PING = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CPU_MEM_BASE = 32'h0000_0400;
  localparam int CPU_ADDR_SHIFT = 3;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } atd_state_t;

  typedef struct packed {
    logic split;
    logic [1:0] kind;
    logic [1:0] token;
    logic [6:0] function_bus_id;
    logic [3:0] endpoint_number;
    logic [15:0] payload_start_pointer;
    logic [14:0] length;
  } atd_cmd_t;

  typedef struct packed {
    logic ack;
    logic nak;
    logic pid_err;
    logic fail;
    logic [14:0] bytes;
  } atd_res_t;

endpackage

// ---- hw/atd_exec.sv ----
// Purpose: Executes one asynchronous host transfer descriptor held in registers.
// Assumes: A packet engine on aclk takes xfer_cmd while xfer_req is high and
//   answers with a one-cycle xfer_done pulse carrying xfer_res.
// Notes: Descriptor words are writable only while the executor is idle.
//   Status reads back busy, valid and ended-with-error in bits 0 to 2.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

module atd_exec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic xfer_req,
  output atd_pkg::atd_cmd_t xfer_cmd,
  input wire logic xfer_done,
  input wire atd_pkg::atd_res_t xfer_res
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    atd_pkg::atd_state_t st;
    logic [3:0][31:0] dw;
    logic [31:0] cpu_addr;
    logic [1:0] pkt_cnt;
    logic ended_err;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic req;
    atd_pkg::atd_cmd_t cmd;
  } atd_regs_t;

  // Ready lines leave reset high so the first request is taken at once.
  localparam atd_regs_t REGS_RESET = '{
    st: atd_pkg::ST_IDLE,
    dw: {4{atd_pkg::WORD_RESET}},
    cpu_addr: atd_pkg::WORD_RESET,
    pkt_cnt: 2'h0,
    ended_err: 1'b0,
    aw_got: 1'b0,
    w_got: 1'b0,
    waddr: 8'h00,
    wdata: atd_pkg::WORD_RESET,
    wstrb: 4'h0,
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: atd_pkg::RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rdata: atd_pkg::WORD_RESET,
    rresp: atd_pkg::RESP_OKAY,
    req: 1'b0,
    cmd: '0
  };

  atd_regs_t s_r;
  atd_regs_t s_nxt;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    // Only byte lanes with their strobe set are replaced.
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] cpu_to_ram(input logic [31:0] cpu);
    logic [31:0] d;
    // An address below the shared memory base wraps; software must stay above it.
    d = cpu - atd_pkg::CPU_MEM_BASE;
    return d[atd_pkg::CPU_ADDR_SHIFT +: 16];
  endfunction

  // Builds the packet command for the next packet of the descriptor.
  function automatic atd_pkg::atd_cmd_t build_cmd(input logic [3:0][31:0] dw);
    atd_pkg::atd_cmd_t c;
    logic [14:0] done;
    logic [14:0] remain;
    logic [14:0] maxp;
    done = dw[3][atd_pkg::W3_DONE_LO +: 15];
    remain = dw[0][atd_pkg::W0_LEN_LO +: 15] - done;
    maxp = {4'h0, dw[0][atd_pkg::W0_MAXPKT_LO +: 11]};
    c.split = dw[1][atd_pkg::W1_SPLIT];
    c.kind = dw[1][atd_pkg::W1_KIND_LO +: 2];
    c.token = dw[1][atd_pkg::W1_TOKEN_LO +: 2];
    c.function_bus_id = dw[1][atd_pkg::W1_FUNC_LO +: 7];
    c.endpoint_number = {dw[1][atd_pkg::W1_EP_HI_LO +: 3], dw[0][atd_pkg::W0_EP_LOW]};
    c.payload_start_pointer = dw[2][atd_pkg::W2_PTR_LO +: 16] + {4'h0, done[14:3]};
    // Each packet carries the smaller of the bytes left and the packet limit.
    c.length = (remain < maxp) ? remain : maxp;
    return c;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [14:0] done_new;
    logic [3:0] nak_new;
    logic [1:0] retry;
    logic [1:0] mult;
    logic [3:0] reload;
    logic [1:0] pkt_new;
    logic [7:0] ra;
    done_new = 15'h0000;
    nak_new = 4'h0;
    retry = s_r.dw[3][atd_pkg::W3_RETRY_LO +: 2];
    mult = s_r.dw[0][atd_pkg::W0_MULT_LO +: 2];
    reload = s_r.dw[2][atd_pkg::W2_RELOAD_LO +: 4];
    pkt_new = s_r.pkt_cnt + 2'h1;
    ra = s_axi_araddr;
    // Every field keeps its value unless a branch below changes it.
    s_nxt = s_r;

    // Write address and data are taken in either order.
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = atd_pkg::RESP_OKAY;
      if (s_r.st != atd_pkg::ST_IDLE) begin
        // Descriptor is locked while a packet is outstanding.
        s_nxt.bresp = atd_pkg::RESP_SLVERR;
      end else if (s_r.waddr[7:4] == 4'h0 && s_r.waddr[1:0] == 2'h0) begin
        s_nxt.dw[s_r.waddr[3:2]] = merge_bytes(s_r.dw[s_r.waddr[3:2]], s_r.wdata,
                                               s_r.wstrb);
        if (s_r.waddr == atd_pkg::OFS_WORD0) begin
          s_nxt.ended_err = 1'b0;
        end
      end else if (s_r.waddr == atd_pkg::OFS_CPU_ADDR) begin
        s_nxt.cpu_addr = merge_bytes(s_r.cpu_addr, s_r.wdata, s_r.wstrb);
        // Writing a processor address loads the mapped pointer.
        s_nxt.dw[2][atd_pkg::W2_PTR_LO +: 16] = cpu_to_ram(s_nxt.cpu_addr);
      end else if (s_r.waddr != atd_pkg::OFS_STATUS) begin
        s_nxt.bresp = atd_pkg::RESP_SLVERR;
      end else begin
        s_nxt.bresp = atd_pkg::RESP_SLVERR;
      end
    end
    // Each ready line stays low from its own take until the write response is accepted.
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

    // Read channel.
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = atd_pkg::RESP_OKAY;
      if (ra[7:4] == 4'h0 && ra[1:0] == 2'h0) begin
        s_nxt.rdata = s_r.dw[ra[3:2]];
      end else if (ra == atd_pkg::OFS_STATUS) begin
        // Bit 0 busy, bit 1 valid, bit 2 ended with error.
        s_nxt.rdata = {29'h0, s_r.ended_err, s_r.dw[0][atd_pkg::W0_VALID],
                       s_r.st == atd_pkg::ST_WAIT};
      end else if (ra == atd_pkg::OFS_CPU_ADDR) begin
        s_nxt.rdata = s_r.cpu_addr;
      end else begin
        s_nxt.rdata = atd_pkg::WORD_RESET;
        s_nxt.rresp = atd_pkg::RESP_SLVERR;
      end
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Descriptor execution.
    unique case (s_r.st)
      atd_pkg::ST_IDLE: begin
        // A descriptor still valid after a pass is launched again from here.
        if (s_r.dw[0][atd_pkg::W0_VALID]) begin
          s_nxt.cmd = build_cmd(s_r.dw);
          s_nxt.req = 1'b1;
          s_nxt.st = atd_pkg::ST_WAIT;
        end
      end
      atd_pkg::ST_WAIT: begin
        // A done pulse without ack, nak or error leaves the descriptor as it was.
        if (xfer_done) begin
          s_nxt.req = 1'b0;
          s_nxt.st = atd_pkg::ST_IDLE;
          s_nxt.pkt_cnt = 2'h0;
          if (xfer_res.ack) begin
            done_new = s_r.dw[3][atd_pkg::W3_DONE_LO +: 15] + xfer_res.bytes;
            s_nxt.dw[3][atd_pkg::W3_DONE_LO +: 15] = done_new;
            s_nxt.dw[3][atd_pkg::W3_NAK_LO +: 4] = reload;
            // A multiplier of zero acts as one, so each pass then holds one packet.
            if (done_new >= s_r.dw[0][atd_pkg::W0_LEN_LO +: 15]) begin
              s_nxt.dw[0][atd_pkg::W0_VALID] = 1'b0;
              s_nxt.dw[3][atd_pkg::W3_ACTIVE] = 1'b0;
            end else if (pkt_new < mult) begin
              // Next packet of the same pass.
              s_nxt.pkt_cnt = pkt_new;
              s_nxt.cmd = build_cmd(s_nxt.dw);
              s_nxt.req = 1'b1;
              s_nxt.st = atd_pkg::ST_WAIT;
            end
          end else if (xfer_res.nak) begin
            if (reload != 4'h0) begin
              // A tally already at zero stays there rather than wrapping round.
              if (s_r.dw[3][atd_pkg::W3_NAK_LO +: 4] != 4'h0) begin
                nak_new = s_r.dw[3][atd_pkg::W3_NAK_LO +: 4] - 4'h1;
              end
              s_nxt.dw[3][atd_pkg::W3_NAK_LO +: 4] = nak_new;
              if (nak_new == 4'h0) begin
                s_nxt.dw[0][atd_pkg::W0_VALID] = 1'b0;
              end
            end
          end else if (xfer_res.pid_err || xfer_res.fail) begin
            // Valid and active drop only once the retry budget is spent.
            if (xfer_res.pid_err) begin
              s_nxt.dw[3][atd_pkg::W3_XERR] = 1'b1;
            end
            if (retry == 2'h0) begin
              s_nxt.dw[0][atd_pkg::W0_VALID] = 1'b0;
              s_nxt.dw[3][atd_pkg::W3_ACTIVE] = 1'b0;
              s_nxt.dw[3][atd_pkg::W3_XERR] = 1'b1;
              s_nxt.ended_err = 1'b1;
            end else begin
              s_nxt.dw[3][atd_pkg::W3_RETRY_LO +: 2] = retry - 2'h1;
            end
          end
        end
      end
      default: begin
        // An illegal state code falls back to idle with no request.
        s_nxt.st = atd_pkg::ST_IDLE;
        s_nxt.req = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------
  // Synchronous reset returns every field to its reset value on one edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= REGS_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign xfer_req = s_r.req;
  assign xfer_cmd = s_r.cmd;

endmodule

// ---- bench/atd_exec_asserts.sv ----
// Purpose: Port-level checks on the descriptor executor.
// Assumes: One aclk domain with synchronous active-low aresetn.
// Notes: Bound into every atd_exec instance.
`timescale 1ns/1ps
module atd_exec_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic xfer_req,
  input wire atd_pkg::atd_cmd_t xfer_cmd,
  input wire logic xfer_done,
  input wire atd_pkg::atd_res_t xfer_res
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write response not on time");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not on time");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
    |=> s_axi_rresp == atd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read answer");
  a_status_ro: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == atd_pkg::OFS_STATUS |=> ##1 s_axi_bresp == atd_pkg::RESP_SLVERR)
    else $error("status write accepted");
  a_cmd_stable: assert property (xfer_req && !xfer_done |=> xfer_req && $stable(xfer_cmd))
    else $error("packet request changed before done");
  a_no_ping: assert property (xfer_req |-> xfer_cmd.token != atd_pkg::TOKEN_PING)
    else $error("hardware issued ping token");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !xfer_req && !s_axi_bvalid
    && !s_axi_rvalid) else $error("outputs busy after reset");
  c_ack: cover property (xfer_done && xfer_res.ack);
  c_nak: cover property (xfer_done && xfer_res.nak);
  c_pid: cover property (xfer_done && xfer_res.pid_err);
  c_fail: cover property (xfer_done && xfer_res.fail);
  c_multi: cover property (xfer_done && xfer_res.ack ##1 xfer_req);
endmodule
bind atd_exec atd_exec_asserts atd_exec_asserts_i (.*);

// ---- bench/atd_engine_model.sv ----
// Purpose: Packet engine standing for devices and hubs beyond the executor.
// Assumes: Answers only while armed by the bench, after lat waiting cycles.
// Notes: Result lines toggle outside the done cycle so stale values never match.
`timescale 1ns/1ps
module atd_engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic xfer_req,
  input wire logic arm,
  input wire logic [3:0] lat,
  input wire atd_pkg::atd_res_t res_sel,
  output logic xfer_done,
  output atd_pkg::atd_res_t xfer_res
);
  logic [3:0] cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      xfer_done <= 1'b0;
      cnt <= 4'h0;
      xfer_res <= '1;
    end else if (!xfer_done && xfer_req && arm && cnt >= lat) begin
      xfer_done <= 1'b1;
      xfer_res <= res_sel;
    end else begin
      xfer_done <= 1'b0;
      xfer_res <= ~xfer_res;
      cnt <= (xfer_req && arm && !xfer_done) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the descriptor executor.
// Assumes: Bench drives bus inputs by non-blocking assignment after rising edges.
// Notes: Each scenario arms the engine model once per packet answer.
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, arm;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, lat;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, xfer_req, xfer_done, req_after;
  atd_pkg::atd_cmd_t xfer_cmd, cmd_seen;
  atd_pkg::atd_res_t xfer_res, res_sel;
  int fails, comparisons;
  localparam logic [31:0] GO8 = {1'b1, 2'h1, 11'h040, 15'h0008, 2'h0, 1'b1};
  localparam logic [31:0] GO16 = {1'b0, 2'h1, 11'h040, 15'h0010, 2'h0, 1'b1};
  localparam logic [31:0] MULT3 = {1'b0, 2'h3, 11'h008, 15'h0018, 2'h0, 1'b1};
  atd_exec atd_exec_i (.*);
  atd_engine_model atd_engine_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t %s seen %h want %h", $time, m, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic resp(input logic [3:0] f, input logic [14:0] b);
    res_sel <= {f, b};
    arm <= 1'b1;
    do @(posedge aclk); while (!xfer_done);
    cmd_seen = xfer_cmd;
    arm <= 1'b0;
    @(posedge aclk);
    req_after = xfer_req;
    @(posedge aclk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    int i;
    for (i = 0; i < 5; i++) begin
      rd(8'(4 * i));
      chk(d, 32'h0, "reset word");
    end
    rd(8'h18);
    chk(r, 32'h2, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    wr(8'h10, 32'h1);
    chk(r, 32'h2, "status write resp");
    $display("t_reset done");
  endtask
  task automatic t_cmd;
    int i;
    logic [1:0] t;
    for (i = 0; i < 3; i++) begin
      t = 2'(i);
      wr(8'h0c, 32'h0);
      wr(8'h14, 32'h0000_0c00);
      wr(8'h04, {17'h0, t[1], t[0] ? 2'h0 : 2'h2, t, 7'h5a, 3'h5});
      chk(r, 32'h0, "write okay");
      wr(8'h00, GO8);
      resp(4'h8, 15'h0008);
      chk(cmd_seen.split, t[1], "split");
      chk(cmd_seen.kind, t[0] ? 32'h0 : 32'h2, "kind");
      chk(cmd_seen.token, t, "token");
      chk(cmd_seen.function_bus_id, 32'h5a, "function id");
      chk(cmd_seen.endpoint_number, 32'hb, "endpoint");
      chk(cmd_seen.payload_start_pointer, 32'h100, "pointer");
      chk(cmd_seen.length, 32'h8, "packet length");
      chk(req_after, 32'h0, "request dropped");
      rd(8'h08);
      chk(d, 32'h0001_0000, "pointer word");
      rd(8'h14);
      chk(d, 32'h0000_0c00, "processor address");
      rd(8'h0c);
      chk(d[14:0], 32'h8, "bytes done");
      chk(r, 32'h0, "read okay");
      rd(8'h00);
      chk(d[0], 32'h0, "valid after done");
    end
    $display("t_cmd done");
  endtask
  task automatic t_nak;
    wr(8'h0c, 32'h8018_0000);
    wr(8'h08, 32'h0600_0000);
    wr(8'h00, GO16);
    repeat (2) resp(4'h4, 15'h0);
    rd(8'h0c);
    chk(d[22:19], 32'h1, "tally after two");
    resp(4'h8, 15'h0008);
    rd(8'h0c);
    chk(d[22:19], 32'h3, "tally reload");
    chk(d[14:0], 32'h8, "partial bytes");
    repeat (3) resp(4'h4, 15'h0);
    rd(8'h00);
    chk(d[0], 32'h0, "valid on tally end");
    $display("t_nak done");
  endtask
  task automatic t_rl0;
    wr(8'h0c, 32'h8000_0000);
    wr(8'h08, 32'h0);
    wr(8'h00, GO8);
    repeat (4) resp(4'h4, 15'h0);
    rd(8'h00);
    chk(d[0], 32'h1, "valid with zero reload");
    lat <= 4'h6;
    resp(4'h8, 15'h0008);
    lat <= 4'h0;
    rd(8'h00);
    chk(d[0], 32'h0, "valid after slow ack");
    $display("t_rl0 done");
  endtask
  task automatic t_retry;
    wr(8'h0c, 32'h8180_0000);
    wr(8'h00, GO8);
    while (!xfer_req) @(posedge aclk);
    wr(8'h04, 32'h0);
    chk(r, 32'h2, "write while busy");
    resp(4'h2, 15'h0);
    rd(8'h0c);
    chk(d[28], 32'h1, "error flag");
    chk(d[24:23], 32'h2, "retry decrement");
    rd(8'h00);
    chk(d[0], 32'h1, "valid while retrying");
    repeat (3) resp(4'h1, 15'h0);
    rd(8'h0c);
    chk(d[31], 32'h0, "active dropped");
    chk(d[24:23], 32'h0, "retry spent");
    rd(8'h00);
    chk(d[0], 32'h0, "valid dropped");
    rd(8'h10);
    chk(d[2], 32'h1, "ended with error");
    chk(d[1:0], 32'h0, "idle and not valid");
    $display("t_retry done");
  endtask
  task automatic t_mult;
    int i;
    wr(8'h0c, 32'h8000_0000);
    s_axi_wstrb <= 4'h2;
    wr(8'h08, 32'hffff_20ff);
    s_axi_wstrb <= 4'hf;
    chk(r, 32'h0, "strobed write resp");
    rd(8'h08);
    chk(d, 32'h0000_2000, "strobed write");
    wr(8'h00, MULT3);
    for (i = 0; i < 3; i++) begin
      resp(4'h8, 15'h0008);
      chk(cmd_seen.payload_start_pointer, 32'h20 + 32'(i), "pass pointer");
      chk(cmd_seen.length, 32'h8, "pass length");
      chk(req_after, (i < 2) ? 32'h1 : 32'h0, "request held in pass");
    end
    rd(8'h0c);
    chk(d[14:0], 32'h18, "pass bytes");
    rd(8'h00);
    chk(d[0], 32'h0, "valid after pass");
    $display("t_mult done");
  endtask
  task automatic finish_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {aresetn, arm, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lat, res_sel} = '0;
    s_axi_wstrb = 4'hf;
    fails = 0;
    comparisons = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_cmd;
    t_nak;
    t_rl0;
    t_retry;
    t_mult;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test;
  end
endmodule
